// file: hdl/skp_panel.sv
// service key timing, action decode and status led patterns
`timescale 1ns/100ps
`default_nettype none
module skp_panel #(
  parameter int unsigned SHORT_MS = skp_pkg::SHORT_MS,
  parameter int unsigned LONG_MS  = skp_pkg::LONG_MS,
  parameter int unsigned DEB_MS   = skp_pkg::DEB_MS,
  parameter int unsigned TICK_CYC = skp_pkg::TICK_CYC
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_key_a_n,
  input  wire logic                     i_key_b_n,
  input  wire logic                     i_boot_done,
  input  wire logic                     i_power_up,
  input  wire logic [2*skp_pkg::NUM_LED-1:0] i_led_pat,
  output logic                          o_usb_cancel,
  output logic                          o_usb_start,
  output logic                          o_load_default,
  output logic                          o_restart,
  output logic                          o_fw_update,
  output logic                          o_test_mode,
  output logic [skp_pkg::NUM_LED-1:0]   o_led,
  output logic [2:0]                    o_led5_rgb
);
  // refuse settings that would overflow the hold, debounce or tick counters
  if (SHORT_MS < 1 || SHORT_MS >= LONG_MS || LONG_MS >= (1 << skp_pkg::HOLD_W)
      || DEB_MS < 1 || DEB_MS > 256 || TICK_CYC < 1 || TICK_CYC > 65536) begin : g_bad_param
    $error("skp_panel: bad timing parameters");
  end

  // millisecond tick
  logic [15:0] tick_cnt_q;
  logic        tick_q;
  wire         tick_end = (tick_cnt_q == 16'(TICK_CYC - 1));
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_end ? 16'h0000 : tick_cnt_q + 16'h0001;
      tick_q     <= tick_end;
    end
  end

  // per key sync, debounce, hold timer; keys are active low at the pin
  logic [1:0] key_n;
  logic [1:0] s1_q, s2_q, deb_q, deb_prev_q;
  logic [1:0] short_ev, long_ev, sus_ev;
  logic [1:0] sus_seen_q;
  assign key_n = {i_key_b_n, i_key_a_n};
  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_key
      logic [7:0]                 deb_cnt_q;
      logic [skp_pkg::HOLD_W-1:0] hold_q;
      wire released    = deb_prev_q[k] & ~deb_q[k];
      // threshold compares; the counter parks at the sustained mark
      wire under_short = (hold_q < (skp_pkg::HOLD_W)'(SHORT_MS));
      wire at_long     = (hold_q == (skp_pkg::HOLD_W)'(LONG_MS));
      // classification only at release or on crossing the sustained mark
      assign short_ev[k] = released & ~sus_seen_q[k] & under_short;
      assign long_ev[k]  = released & ~sus_seen_q[k] & ~under_short;
      assign sus_ev[k]   = deb_q[k] & tick_q & ~sus_seen_q[k] & at_long;
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          s1_q[k] <= 1'b0;
          s2_q[k] <= 1'b0;
          deb_q[k] <= 1'b0;
          deb_prev_q[k] <= 1'b0;
          deb_cnt_q <= 8'h00;
          hold_q <= '0;
          sus_seen_q[k] <= 1'b0;
        end else begin
          s1_q[k] <= ~key_n[k];
          s2_q[k] <= s1_q[k];
          deb_prev_q[k] <= deb_q[k];
          // the level must stay different for DEB_MS ticks before it is accepted
          if (s2_q[k] == deb_q[k]) deb_cnt_q <= 8'h00;
          else if (tick_q) begin
            if (deb_cnt_q == 8'(DEB_MS - 1)) begin
              deb_q[k] <= s2_q[k];
              deb_cnt_q <= 8'h00;
            end else deb_cnt_q <= deb_cnt_q + 8'h01;
          end
          // saturating ms hold counter
          if (!deb_q[k]) hold_q <= '0;
          else if (tick_q && !at_long) hold_q <= hold_q + (skp_pkg::HOLD_W)'(1);
          if (!deb_q[k]) sus_seen_q[k] <= 1'b0;
          else if (sus_ev[k]) sus_seen_q[k] <= 1'b1;
        end
      end
    end
  endgenerate

  // mode machine and actions
  skp_pkg::skp_mode_type mode_q;
  wire both_sus = deb_q[0] & deb_q[1] & (|sus_ev) & (sus_seen_q[0] | sus_ev[0])
                  & (sus_seen_q[1] | sus_ev[1]);
  wire a_only_sus = sus_ev[0] & ~deb_q[1];
  wire active = (mode_q != skp_pkg::SKP_BOOT);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_q <= skp_pkg::SKP_BOOT;
      o_usb_cancel <= 1'b0;
      o_usb_start <= 1'b0;
      o_load_default <= 1'b0;
      o_restart <= 1'b0;
      o_fw_update <= 1'b0;
      o_test_mode <= 1'b0;
    end else begin
      o_usb_cancel   <= active & short_ev[0];
      o_usb_start    <= active & short_ev[1];
      o_load_default <= (mode_q == skp_pkg::SKP_TEST) & long_ev[1];
      o_restart      <= (mode_q == skp_pkg::SKP_RUN) & both_sus & ~i_power_up;
      o_fw_update    <= both_sus & i_power_up;
      unique case (mode_q)
        skp_pkg::SKP_BOOT: if (i_boot_done) mode_q <= skp_pkg::SKP_RUN;
        skp_pkg::SKP_RUN:  if (a_only_sus) mode_q <= skp_pkg::SKP_TEST;
        skp_pkg::SKP_TEST: if (a_only_sus) mode_q <= skp_pkg::SKP_RUN;
        default:           mode_q <= skp_pkg::SKP_BOOT;
      endcase
      o_test_mode <= (mode_q == skp_pkg::SKP_TEST);
    end
  end

  // blink phases from the ms tick
  logic [9:0] slow_cnt_q;
  logic [7:0] fast_cnt_q;
  logic       slow_ph_q, fast_ph_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      slow_cnt_q <= 10'h000;
      fast_cnt_q <= 8'h00;
      slow_ph_q <= 1'b1;
      fast_ph_q <= 1'b1;
    end else if (tick_q) begin
      if (slow_cnt_q == 10'(skp_pkg::SLOW_HALF_MS - 1)) begin
        slow_cnt_q <= 10'h000;
        slow_ph_q <= ~slow_ph_q;
      end else slow_cnt_q <= slow_cnt_q + 10'h001;
      if (fast_cnt_q == 8'(skp_pkg::FAST_HALF_MS - 1)) begin
        fast_cnt_q <= 8'h00;
        fast_ph_q <= ~fast_ph_q;
      end else fast_cnt_q <= fast_cnt_q + 8'h01;
    end
  end

  // led drivers; led5 stays dark until booted
  logic [skp_pkg::NUM_LED-1:0] led_d;
  generate
    for (k = 0; k < skp_pkg::NUM_LED; k++) begin : g_led
      wire [1:0] pat = i_led_pat[2*k +: 2];
      assign led_d[k] = (pat == skp_pkg::PAT_ON) | ((pat == skp_pkg::PAT_SLOW) & slow_ph_q)
                        | ((pat == skp_pkg::PAT_FAST) & fast_ph_q);
      // steady codes must reach the pin one cycle later
      led_steady_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (pat == skp_pkg::PAT_ON || pat == skp_pkg::PAT_OFF)
        |=> o_led[k] == ($past(pat) == skp_pkg::PAT_ON)) else $error("steady led wrong");
    end
  endgenerate
  wire [2:0] rgb_d = (mode_q == skp_pkg::SKP_RUN)  ? skp_pkg::RGB_GREEN :
                     (mode_q == skp_pkg::SKP_TEST) ? skp_pkg::RGB_MAGENTA : skp_pkg::RGB_OFF;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_led <= '0;
      o_led5_rgb <= skp_pkg::RGB_OFF;
    end else begin
      o_led <= led_d;
      o_led5_rgb <= rgb_d;
    end
  end

  // checks
  sequence slow_wrap_s;
    tick_q && slow_cnt_q == 10'(skp_pkg::SLOW_HALF_MS - 1);
  endsequence
  slow_phase_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    slow_wrap_s |=> slow_ph_q != $past(slow_ph_q)) else $error("slow phase not toggled");
  fast_phase_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tick_q && fast_cnt_q == 8'(skp_pkg::FAST_HALF_MS - 1) |=> fast_ph_q != $past(fast_ph_q))
    else $error("fast phase not toggled");
  fast_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(tick_q && fast_cnt_q == 8'(skp_pkg::FAST_HALF_MS - 1)) |=> $stable(fast_ph_q))
    else $error("fast phase moved early");
  usb_cancel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_usb_cancel |-> $past(short_ev[0]) && $past(mode_q) != skp_pkg::SKP_BOOT)
    else $error("usb cancel without cause");
  usb_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    active && short_ev[1] |=> o_usb_start) else $error("usb start missed");
  mode_toggle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mode_q == skp_pkg::SKP_RUN && a_only_sus |=> mode_q == skp_pkg::SKP_TEST ##1 o_test_mode)
    else $error("test mode not entered");
  load_def_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_load_default |-> $past(mode_q) == skp_pkg::SKP_TEST)
    else $error("default load outside test");
  fw_upd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_fw_update |-> $past(i_power_up) && !o_restart) else $error("update without power-up");
  restart_run_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_restart |-> $past(mode_q) == skp_pkg::SKP_RUN && !$past(i_power_up))
    else $error("restart outside run");
  deb_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $changed(deb_q[0]) |-> $past(tick_q) && $past(s2_q[0]) != $past(deb_q[0]))
    else $error("debounce moved off tick");
  short_lim_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    long_ev[0] |-> !short_ev[0] && g_key[0].hold_q >= (skp_pkg::HOLD_W)'(SHORT_MS))
    else $error("press class wrong");
  led5_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mode_q == skp_pkg::SKP_TEST ##1 mode_q == skp_pkg::SKP_TEST
    |-> o_led5_rgb == skp_pkg::RGB_MAGENTA)
    else $error("led5 colour wrong");
endmodule
`default_nettype wire

// file: shared/skp_pkg.sv
// constants and types for the service key and led panel
package skp_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_NS       = 1_000_000;      // 1 ms timebase in ns
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_CYC      = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SHORT_MS      = 1000;           // short press limit, 1 s
  localparam int unsigned LONG_MS       = 4000;           // long press limit, 4 s
  localparam int unsigned SLOW_HALF_MS  = 1000;           // slow blink on/off time, 1 s
  localparam int unsigned FAST_HALF_MS  = 250;            // fast blink on/off time, 0.25 s
  localparam int unsigned DEB_MS        = 20;             // debounce settle time
  localparam int unsigned HOLD_W        = 13;
  localparam int unsigned NUM_LED       = 4;
  localparam int unsigned PAT_W         = 2;
  // led pattern codes
  localparam logic [1:0]  PAT_OFF       = 2'h0;
  localparam logic [1:0]  PAT_ON        = 2'h1;
  localparam logic [1:0]  PAT_SLOW      = 2'h2;
  localparam logic [1:0]  PAT_FAST      = 2'h3;
  // status led colour as r,g,b
  localparam logic [2:0]  RGB_GREEN     = 3'h2;
  localparam logic [2:0]  RGB_MAGENTA   = 3'h5;
  localparam logic [2:0]  RGB_OFF       = 3'h0;
  typedef enum logic [1:0] {SKP_BOOT, SKP_RUN, SKP_TEST} skp_mode_type;
endpackage

// file: verification/skp_key_model.sv
// service key model with pull-ups and contact chatter
`timescale 1ns/100ps
`default_nettype none
module skp_key_model (
  input  wire logic i_clk,
  input  wire logic i_press_a,
  input  wire logic i_press_b,
  output logic      o_key_a_n,
  output logic      o_key_b_n
);
  logic [1:0] last_q = 2'h0;
  logic [2:0] bnc_q  = 3'h0;
  // chatter after each change, shorter than debounce, so a raw edge is never trusted
  always_ff @(posedge i_clk) begin
    last_q <= {i_press_b, i_press_a};
    bnc_q  <= (last_q != {i_press_b, i_press_a}) ? 3'h5 : bnc_q >> 1;
  end
  // released key reads high through its pull-up
  assign o_key_a_n = ~i_press_a ^ bnc_q[0];
  assign o_key_b_n = ~i_press_b ^ bnc_q[0];
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the service key and led panel
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned TC = 10;
  localparam int unsigned W  = 2 * skp_pkg::SLOW_HALF_MS * TC;
  logic       clk = 1'b0, rst_n = 1'b0, pa = 1'b0, pb = 1'b0, boot = 1'b0, pwr = 1'b0;
  logic [7:0] pat = 8'h00;
  logic       ka_n, kb_n, test;
  logic [4:0] pul;
  logic [3:0] led;
  logic [2:0] rgb;
  logic [7:0] cnt [5];
  int         error_cnt = 0, samples_checked = 0;
  int unsigned rot;
  initial forever #50 clk = ~clk;
  skp_key_model key_u (.i_clk(clk), .i_press_a(pa), .i_press_b(pb),
    .o_key_a_n(ka_n), .o_key_b_n(kb_n));
  // short counts keep the run brief; blink halves stay at full length
  skp_panel #(.SHORT_MS(10), .LONG_MS(40), .DEB_MS(2), .TICK_CYC(TC)) dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_key_a_n(ka_n), .i_key_b_n(kb_n),
    .i_boot_done(boot), .i_power_up(pwr), .i_led_pat(pat),
    .o_usb_cancel(pul[0]), .o_usb_start(pul[1]), .o_load_default(pul[2]),
    .o_restart(pul[3]), .o_fw_update(pul[4]), .o_test_mode(test),
    .o_led(led), .o_led5_rgb(rgb));
  // pulse tallies per action output
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) cnt[i] <= rst_n ? cnt[i] + 8'(pul[i]) : 8'h00;
  end
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // hold keys for ms, release, then compare action pulses seen
  task automatic act(input string nm, input logic a, b, input int ms, input logic [4:0] e);
    logic [7:0] s [5];
    s = cnt;
    pa <= a;
    pb <= b;
    repeat (ms * TC) @(posedge clk);
    pa <= 1'b0;
    pb <= 1'b0;
    repeat (12 * TC) @(posedge clk);
    for (int i = 0; i < 5; i++) check(nm, 16'(e[i]), 16'(cnt[i] - s[i]));
    $display("test %s done", nm);
  endtask
  function automatic logic [15:0] exp_lit(input logic [1:0] p);
    return (p == skp_pkg::PAT_OFF) ? 16'h0 : (p == skp_pkg::PAT_ON) ? 16'(W) : 16'(W / 2);
  endfunction
  function automatic logic [15:0] exp_rise(input logic [1:0] p);
    if (p == skp_pkg::PAT_SLOW) return 16'h1;
    return (p == skp_pkg::PAT_FAST) ? 16'(W / (2 * skp_pkg::FAST_HALF_MS * TC)) : 16'h0;
  endfunction
  // count lit cycles and rising edges over one full slow period
  task automatic leds;
    int lit [4] = '{default: 0};
    int rise [4] = '{default: 0};
    logic [3:0] prv;
    repeat (3) @(posedge clk);
    #1 prv = led;
    repeat (W) begin
      @(posedge clk);
      #1;
      for (int k = 0; k < 4; k++) begin
        lit[k] += int'(led[k] === 1'b1);
        rise[k] += int'(led[k] === 1'b1 && prv[k] === 1'b0);
      end
      prv = led;
    end
    for (int k = 0; k < 4; k++) check("led lit", exp_lit(pat[2*k+:2]), 16'(lit[k]));
    for (int k = 0; k < 4; k++) begin
      check("led rise", exp_rise(pat[2*k+:2]), 16'(rise[k]));
    end
    // back onto a clock edge so the next drive lands on it
    @(posedge clk);
    $display("test leds done");
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #8_000_000;
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h42d6));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 check("rgb boot", 16'(skp_pkg::RGB_OFF), 16'(rgb));
    @(posedge clk);
    act("a short boot", 1, 0, 5, 5'h00);
    boot <= 1'b1;
    repeat (3) @(posedge clk);
    check("rgb run", 16'(skp_pkg::RGB_GREEN), 16'(rgb));
    act("a short", 1, 0, 3 + $urandom % 5, 5'h01);
    act("b short", 0, 1, 3 + $urandom % 5, 5'h02);
    act("b long run", 0, 1, 12 + $urandom % 24, 5'h00);
    act("a long", 1, 0, 12 + $urandom % 24, 5'h00);
    act("a sustained", 1, 0, 45, 5'h00);
    check("test mode", 16'h1, 16'(test));
    check("rgb test", 16'(skp_pkg::RGB_MAGENTA), 16'(rgb));
    act("b long test", 0, 1, 12 + $urandom % 24, 5'h04);
    act("a sustained back", 1, 0, 45, 5'h00);
    check("run mode", 16'h0, 16'(test));
    // one random rotation keeps all four codes present
    rot = $urandom % 4;
    pat <= (8'hE4 << (2 * rot)) | (8'hE4 >> (8 - 2 * rot));
    leds();
    act("both sustained", 1, 1, 45, 5'h08);
    pwr <= 1'b1;
    act("both power-up", 1, 1, 45, 5'h10);
    finish_test();
  end
endmodule
`default_nettype wire
